// >>> fdsm_checker.sv
// concurrent checks on the ports of fdsm_top
// assumes binding to fdsm_top, one clock domain on MCLK
`timescale 1ns/1ps
module fdsm_checker (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET_N,
	// register port
	input wire logic REG_RE,
	input wire logic [7:0] REG_RDATA,
	input wire logic REG_RVALID,
	// fractional path
	input wire logic [23:0] EFF_DIVIDER,
	input wire logic [24:0] TOTAL_DIVISION,
	input wire logic MOD_ACTIVE,
	input wire logic RAMP_UP,
	input wire logic [1:0] MULT_SELECT,
	input wire logic [3:0] MULT_QUARTERS,
	input wire logic MULT_ENABLE
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESET_N);
	// settled ramp halves, long enough to cover the output lag
	sequence s_down;
		(MOD_ACTIVE && !RAMP_UP) [*4];
	endsequence
	sequence s_up;
		(MOD_ACTIVE && RAMP_UP) [*4];
	endsequence
	a_read_answer: assert property (REG_RE |-> ##2 REG_RVALID)
		else $error("read valid missing");
	a_valid_cause: assert property (
		REG_RVALID |-> $past(REG_RE, 2))
		else $error("read valid without read");
	a_rdata_hold: assert property (
		!REG_RVALID |-> $stable(REG_RDATA))
		else $error("read data moved");
	a_total_twice: assert property (
		TOTAL_DIVISION == {EFF_DIVIDER, 1'b0})
		else $error("total division not twice divider");
	a_down_ramp: assert property (
		s_down |-> EFF_DIVIDER <= $past(EFF_DIVIDER))
		else $error("divider rose in down ramp");
	a_up_ramp: assert property (
		s_up |-> EFF_DIVIDER >= $past(EFF_DIVIDER))
		else $error("divider fell in up ramp");
	a_mult_table: assert property (MULT_QUARTERS ==
		(MULT_SELECT == 2'b00 ? 4'h1 : MULT_SELECT == 2'b01 ? 4'h4 :
		MULT_SELECT == 2'b10 ? 4'h5 : 4'h8))
		else $error("multiplier code wrong");
	a_spread_mult: assert property (
		MOD_ACTIVE && $past(MOD_ACTIVE) |-> MULT_ENABLE)
		else $error("multiplier off during spread");
	a_ramp_active: assert property (RAMP_UP |-> MOD_ACTIVE)
		else $error("ramp flag while idle");
endmodule
bind fdsm_top fdsm_checker chk_i (.MCLK, .RESET_N, .REG_RE, .REG_RDATA,
	.REG_RVALID, .EFF_DIVIDER, .TOTAL_DIVISION, .MOD_ACTIVE, .RAMP_UP,
	.MULT_SELECT, .MULT_QUARTERS, .MULT_ENABLE);

// >>> fdsm_consts.svh
// register offsets, field positions, reset values and counts for the
// fractional divider and spread modulation block
// assumes inclusion by bare name from the top module
`ifndef FDSM_CONSTS_SVH
`define FDSM_CONSTS_SVH

`define FDSM_ADDR_SS_CTRL 8'h10
`define FDSM_ADDR_SS_PER_LO 8'h11
`define FDSM_ADDR_DIV_INT 8'h12
`define FDSM_ADDR_DIV_FR_HI 8'h13
`define FDSM_ADDR_DIV_FR_LO 8'h14
`define FDSM_ADDR_SS_STEP_HI 8'h15
`define FDSM_ADDR_SS_STEP_LO 8'h16
`define FDSM_ADDR_FB_DIV 8'h1F
`define FDSM_ADDR_IDIV_A_LO 8'h20
`define FDSM_ADDR_IDIV_B_LO 8'h21
`define FDSM_ADDR_IDIV_HI 8'h22
`define FDSM_ADDR_MULT_SEL 8'h24

`define FDSM_SS_EN_BIT 7
`define FDSM_MULT_EN_BIT 2

`define FDSM_RST_BYTE 8'h00
`define FDSM_RST_CTRL 5'h00
`define FDSM_RST_MULT 3'h0

// multiplier in quarter units
`define FDSM_MULT_Q_00 4'h1
`define FDSM_MULT_Q_01 4'h4
`define FDSM_MULT_Q_10 4'h5
`define FDSM_MULT_Q_11 4'h8

`define FDSM_PRE_DIV 2
`define FDSM_STEP_FRAC_BITS 24
`define FDSM_DIV_FRAC_BITS 16

`endif

// >>> fdsm_host.sv
// partner model: host writing and reading the byte register port
// assumes the bench calls wr and rd; signals change at falling edges
`timescale 1ns/1ps
module fdsm_host (
	// clock
	input wire logic clk,
	// register port
	output logic [7:0] addr,
	output logic [7:0] wdata,
	output logic we,
	output logic re,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	initial {addr, wdata, we, re} = '0;
	// a released bus shows the inverse of the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		@(negedge clk);
		addr = a;
		wdata = x;
		we = 1'b1;
		@(negedge clk);
		we = 1'b0;
		addr = ~a;
		wdata = ~x;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] x,
		output logic v);
		@(negedge clk);
		addr = a;
		re = 1'b1;
		@(negedge clk);
		re = 1'b0;
		addr = ~a;
		// valid stands for one cycle only, two edges after the read
		@(negedge clk);
		x = rdata;
		v = rvalid;
	endtask
endmodule

// >>> fdsm_pkg.sv
// types shared by the fractional divider and spread modulation block
// assumes fdsm_consts.svh is on the include path
package fdsm_pkg;
	typedef enum logic [2:0] {
		FDSM_IDLE = 3'b001,
		FDSM_DOWN = 3'b010,
		FDSM_UP = 3'b100
	} fdsm_state_e;

	typedef struct packed {
		logic ss_en;
		logic [11:0] period;
		logic [15:0] step;
		logic [7:0] div_int;
		logic [15:0] div_frac;
	} fdsm_cfg_s;
endpackage

// >>> fdsm_top.sv
// fractional output divider with triangular spread modulation, its
// register bank, multiplier selection and integer divider settings
// assumes a byte register port driven by an i2c slave on MCLK and a
// one-cycle STEP_TICK per fractional divider output cycle, same clock
//
// Operation
// - divider: 8-bit integer, 16-bit fraction high first
// - fixed divide-by-two ahead of fractional divider
// - feedback and integer divider values held, exported
// - spread enable bit gates modulation, enables multiplier
// - 12-bit half-period split across two registers
// - 16-bit step sets ramp slope, high first
// - selector picks x0.25, x1, x1.25, x2
// - triangle modulation rate tracks output frequency
// - only fractional path is ever modulated
// - modulated divider never exceeds programmed base
// - one step per output cycle, half-count doubled
`timescale 1ns/1ps
`include "fdsm_consts.svh"

module fdsm_top (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET_N,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WE,
	input wire logic REG_RE,
	output logic [7:0] REG_RDATA,
	output logic REG_RVALID,
	// time step
	input wire logic STEP_TICK,
	// fractional path
	output logic [23:0] EFF_DIVIDER,
	output logic [24:0] TOTAL_DIVISION,
	output logic MOD_ACTIVE,
	output logic RAMP_UP,
	output logic [1:0] MULT_SELECT,
	output logic [3:0] MULT_QUARTERS,
	output logic MULT_ENABLE,
	// integer path
	output logic [7:0] FEEDBACK_DIVIDER,
	output logic [11:0] INT_DIVIDER_A,
	output logic [11:0] INT_DIVIDER_B
);
	import fdsm_pkg::*;

	logic [4:0] spread_ctrl_period_high, next_spread_ctrl_period_high;
	logic [7:0] spread_period_low, next_spread_period_low;
	logic [7:0] divider_integer_part, next_divider_integer_part;
	logic [7:0] divider_fraction_high, next_divider_fraction_high;
	logic [7:0] divider_fraction_low, next_divider_fraction_low;
	logic [7:0] spread_step_high, next_spread_step_high;
	logic [7:0] spread_step_low, next_spread_step_low;
	logic [7:0] feedback_divider, next_feedback_divider;
	logic [7:0] int_div_a_low, next_int_div_a_low;
	logic [7:0] int_div_b_low, next_int_div_b_low;
	logic [7:0] int_div_high, next_int_div_high;
	logic [2:0] multiplier_select, next_multiplier_select;
	logic [7:0] rdata, next_rdata;
	logic rvalid, next_rvalid;

	fdsm_cfg_s cfg;
	fdsm_state_e state, next_state;
	logic [31:0] offset, next_offset;
	logic [12:0] count, next_count;
	logic [23:0] eff, next_eff;
	logic [3:0] next_mult_q;
	logic [12:0] half_steps;
	logic [12:0] count_inc;
	logic [31:0] base;
	logic [31:0] step_ext;

	// ctrl register keeps the bit-7 enable in bit 4 and period[11:8] in bits 3..0
	always_comb begin
		cfg.ss_en = spread_ctrl_period_high[4];
		cfg.period = {spread_ctrl_period_high[3:0], spread_period_low};
		cfg.step = {spread_step_high, spread_step_low};
		cfg.div_int = divider_integer_part;
		cfg.div_frac = {divider_fraction_high, divider_fraction_low};
	end

	// register writes and reads
	always_comb begin
		next_spread_ctrl_period_high = spread_ctrl_period_high;
		next_spread_period_low = spread_period_low;
		next_divider_integer_part = divider_integer_part;
		next_divider_fraction_high = divider_fraction_high;
		next_divider_fraction_low = divider_fraction_low;
		next_spread_step_high = spread_step_high;
		next_spread_step_low = spread_step_low;
		next_feedback_divider = feedback_divider;
		next_int_div_a_low = int_div_a_low;
		next_int_div_b_low = int_div_b_low;
		next_int_div_high = int_div_high;
		next_multiplier_select = multiplier_select;
		if (REG_WE) begin
			case (REG_ADDR)
				`FDSM_ADDR_SS_CTRL: begin
					next_spread_ctrl_period_high = {REG_WDATA[`FDSM_SS_EN_BIT],
						REG_WDATA[3:0]};
				end
				`FDSM_ADDR_SS_PER_LO: next_spread_period_low = REG_WDATA;
				`FDSM_ADDR_DIV_INT: next_divider_integer_part = REG_WDATA;
				`FDSM_ADDR_DIV_FR_HI: next_divider_fraction_high = REG_WDATA;
				`FDSM_ADDR_DIV_FR_LO: next_divider_fraction_low = REG_WDATA;
				`FDSM_ADDR_SS_STEP_HI: next_spread_step_high = REG_WDATA;
				`FDSM_ADDR_SS_STEP_LO: next_spread_step_low = REG_WDATA;
				`FDSM_ADDR_FB_DIV: next_feedback_divider = REG_WDATA;
				`FDSM_ADDR_IDIV_A_LO: next_int_div_a_low = REG_WDATA;
				`FDSM_ADDR_IDIV_B_LO: next_int_div_b_low = REG_WDATA;
				`FDSM_ADDR_IDIV_HI: next_int_div_high = REG_WDATA;
				`FDSM_ADDR_MULT_SEL: next_multiplier_select = REG_WDATA[2:0];
				default: begin
				end
			endcase
		end
		next_rvalid = REG_RE;
		next_rdata = rdata;
		if (REG_RE) begin
			case (REG_ADDR)
				`FDSM_ADDR_SS_CTRL: begin
					next_rdata = {spread_ctrl_period_high[4], 3'h0,
						spread_ctrl_period_high[3:0]};
				end
				`FDSM_ADDR_SS_PER_LO: next_rdata = spread_period_low;
				`FDSM_ADDR_DIV_INT: next_rdata = divider_integer_part;
				`FDSM_ADDR_DIV_FR_HI: next_rdata = divider_fraction_high;
				`FDSM_ADDR_DIV_FR_LO: next_rdata = divider_fraction_low;
				`FDSM_ADDR_SS_STEP_HI: next_rdata = spread_step_high;
				`FDSM_ADDR_SS_STEP_LO: next_rdata = spread_step_low;
				`FDSM_ADDR_FB_DIV: next_rdata = feedback_divider;
				`FDSM_ADDR_IDIV_A_LO: next_rdata = int_div_a_low;
				`FDSM_ADDR_IDIV_B_LO: next_rdata = int_div_b_low;
				`FDSM_ADDR_IDIV_HI: next_rdata = int_div_high;
				`FDSM_ADDR_MULT_SEL: next_rdata = {5'h00, multiplier_select};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			spread_ctrl_period_high <= `FDSM_RST_CTRL;
			spread_period_low <= `FDSM_RST_BYTE;
			divider_integer_part <= `FDSM_RST_BYTE;
			divider_fraction_high <= `FDSM_RST_BYTE;
			divider_fraction_low <= `FDSM_RST_BYTE;
			spread_step_high <= `FDSM_RST_BYTE;
			spread_step_low <= `FDSM_RST_BYTE;
			feedback_divider <= `FDSM_RST_BYTE;
			int_div_a_low <= `FDSM_RST_BYTE;
			int_div_b_low <= `FDSM_RST_BYTE;
			int_div_high <= `FDSM_RST_BYTE;
			multiplier_select <= `FDSM_RST_MULT;
			rdata <= `FDSM_RST_BYTE;
			rvalid <= 1'b0;
		end else begin
			spread_ctrl_period_high <= next_spread_ctrl_period_high;
			spread_period_low <= next_spread_period_low;
			divider_integer_part <= next_divider_integer_part;
			divider_fraction_high <= next_divider_fraction_high;
			divider_fraction_low <= next_divider_fraction_low;
			spread_step_high <= next_spread_step_high;
			spread_step_low <= next_spread_step_low;
			feedback_divider <= next_feedback_divider;
			int_div_a_low <= next_int_div_a_low;
			int_div_b_low <= next_int_div_b_low;
			int_div_high <= next_int_div_high;
			multiplier_select <= next_multiplier_select;
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	// modulation engine; divider kept with 24 fraction bits to match step
	always_comb begin
		base = {cfg.div_int, cfg.div_frac, 8'h00};
		step_ext = {16'h0000, cfg.step};
		half_steps = {cfg.period, 1'b0};
		count_inc = count + 13'h0001;
		next_state = state;
		next_offset = offset;
		next_count = count;
		case (state)
			FDSM_IDLE: begin
				next_offset = 32'h0000_0000;
				next_count = 13'h0000;
				if (cfg.ss_en && half_steps != 13'h0000) begin
					next_state = FDSM_DOWN;
				end
			end
			FDSM_DOWN: begin
				if (STEP_TICK) begin
					next_offset = offset + step_ext;
					next_count = count_inc;
					if (count_inc >= half_steps) begin
						next_state = FDSM_UP;
						next_count = 13'h0000;
					end
				end
			end
			FDSM_UP: begin
				if (STEP_TICK) begin
					// clamp keeps the divider at or under base
					next_offset = (offset >= step_ext) ?
						offset - step_ext : 32'h0000_0000;
					next_count = count_inc;
					if (count_inc >= half_steps) begin
						next_state = FDSM_DOWN;
						next_count = 13'h0000;
					end
				end
			end
			default: begin
				next_state = FDSM_IDLE;
				next_offset = 32'h0000_0000;
				next_count = 13'h0000;
			end
		endcase
		// disabled spread ignores period and step entirely
		if (!cfg.ss_en || half_steps == 13'h0000) begin
			next_state = FDSM_IDLE;
			next_offset = 32'h0000_0000;
			next_count = 13'h0000;
		end
		// offset can never pass base, so the difference never wraps
		if (next_offset > base) begin
			next_offset = base;
		end
		next_eff = base[31:8] - next_offset[31:8];
		case (multiplier_select[1:0])
			2'b00: next_mult_q = `FDSM_MULT_Q_00;
			2'b01: next_mult_q = `FDSM_MULT_Q_01;
			2'b10: next_mult_q = `FDSM_MULT_Q_10;
			2'b11: next_mult_q = `FDSM_MULT_Q_11;
			default: next_mult_q = `FDSM_MULT_Q_01;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			state <= FDSM_IDLE;
			offset <= 32'h0000_0000;
			count <= 13'h0000;
			eff <= 24'h000000;
		end else begin
			state <= next_state;
			offset <= next_offset;
			count <= next_count;
			eff <= next_eff;
		end
	end

	// output registers
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			EFF_DIVIDER <= 24'h000000;
			TOTAL_DIVISION <= 25'h0000000;
			MOD_ACTIVE <= 1'b0;
			RAMP_UP <= 1'b0;
			MULT_SELECT <= 2'h0;
			MULT_QUARTERS <= `FDSM_MULT_Q_00;
			MULT_ENABLE <= 1'b0;
			FEEDBACK_DIVIDER <= `FDSM_RST_BYTE;
			INT_DIVIDER_A <= 12'h000;
			INT_DIVIDER_B <= 12'h000;
			REG_RDATA <= `FDSM_RST_BYTE;
			REG_RVALID <= 1'b0;
		end else begin
			EFF_DIVIDER <= eff;
			TOTAL_DIVISION <= {eff, 1'b0};
			MOD_ACTIVE <= (state != FDSM_IDLE);
			RAMP_UP <= (state == FDSM_UP);
			MULT_SELECT <= multiplier_select[1:0];
			// quarters move in the same cycle as MULT_SELECT
			MULT_QUARTERS <= next_mult_q;
			// stays on until the engine is idle, so it covers MOD_ACTIVE
			MULT_ENABLE <= multiplier_select[`FDSM_MULT_EN_BIT] |
				cfg.ss_en | (state != FDSM_IDLE);
			FEEDBACK_DIVIDER <= feedback_divider;
			// integer path taken straight from registers, never modulated
			INT_DIVIDER_A <= {int_div_high[3:0], int_div_a_low};
			INT_DIVIDER_B <= {int_div_high[7:4], int_div_b_low};
			REG_RDATA <= rdata;
			REG_RVALID <= rvalid;
		end
	end
endmodule

// >>> fractional_divider_spread_mod_tb.sv
// self-checking bench for fdsm_top against an integer model
// assumes fdsm_host drives the register port, 40 MHz MCLK
`timescale 1ns/1ps
module fractional_divider_spread_mod_tb;
	logic mclk, reset_n, step_tick, we, re, rvalid, mod_active, ramp_up;
	logic mult_en, v;
	logic [7:0] addr, wdata, rdata, fb_div, d;
	logic [1:0] mult_sel;
	logic [3:0] mult_q;
	logic [11:0] int_a, int_b;
	logic [23:0] eff, base;
	logic [24:0] total;
	logic [7:0] mdl [0:255];
	int qtab [4] = '{1, 4, 5, 8};
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	int seed, off, cnt, per, stp, up, en;
	fdsm_top DUT (.MCLK(mclk), .RESET_N(reset_n), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata),
		.REG_RVALID(rvalid), .STEP_TICK(step_tick), .EFF_DIVIDER(eff),
		.TOTAL_DIVISION(total), .MOD_ACTIVE(mod_active), .RAMP_UP(ramp_up),
		.MULT_SELECT(mult_sel), .MULT_QUARTERS(mult_q),
		.MULT_ENABLE(mult_en), .FEEDBACK_DIVIDER(fb_div),
		.INT_DIVIDER_A(int_a), .INT_DIVIDER_B(int_b));
	fdsm_host host (.clk(mclk), .addr(addr), .wdata(wdata), .we(we),
		.re(re), .rdata(rdata), .rvalid(rvalid));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		forever begin
			@(posedge mclk);
			cyc++;
			if (cyc == 6000) begin
				n_fail++;
				wrap_up();
			end
		end
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// readable bits of each register; unmapped places read zero
	function automatic logic [7:0] msk(input logic [7:0] a);
		case (a)
			8'h10: return 8'h8F;
			8'h24: return 8'h07;
			8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h1F, 8'h20,
				8'h21, 8'h22: return 8'hFF;
			default: return 8'h00;
		endcase
	endfunction
	task automatic put(input logic [7:0] a, input logic [7:0] x);
		host.wr(a, x);
		mdl[a] = x & msk(a);
	endtask
	task automatic get(input logic [7:0] a);
		host.rd(a, d, v);
		chk("rvalid", 1, v);
		chk("rdata", mdl[a], d);
	endtask
	task automatic tick();
		@(negedge mclk);
		step_tick = 1'b1;
		@(negedge mclk);
		step_tick = 1'b0;
		if (en == 1) begin
			off = (up == 0) ? off + stp : (off > stp ? off - stp : 0);
			cnt++;
			if (cnt == 2 * per) begin
				up = 1 - up;
				cnt = 0;
			end
		end
		repeat (3) @(negedge mclk);
		chk("eff", base - (off >> 8), eff);
		chk("total", 2 * (base - (off >> 8)), total);
		chk("ramp_up", up, ramp_up);
	endtask
	initial begin
		reset_n = 1'b0;
		step_tick = 1'b0;
		{off, cnt, up, en} = '0;
		foreach (mdl[i]) mdl[i] = 8'h00;
		seed = $urandom(99);
		repeat (12) @(negedge mclk);
		reset_n = 1'b1;
		chk("mult_q", 4'h1, mult_q);
		put(8'h17, 8'hA5);
		for (int a = 8'h0F; a <= 8'h25; a++) get(8'(a));
		$display("test reset values done");
		// integer dividers kept at 256 or more, fractional integer at 4 or more
		for (int a = 8'h0F; a <= 8'h25; a++)
			put(8'(a), (8'($urandom) & (a == 8'h10 ? 8'h7F : 8'hFF)) |
				(a == 8'h22 ? 8'h11 : (a == 8'h12 ? 8'h04 : 8'h00)));
		for (int a = 8'h0F; a <= 8'h25; a++) get(8'(a));
		chk("fb_div", mdl[8'h1F], fb_div);
		chk("int_a", {mdl[8'h22][3:0], mdl[8'h20]}, int_a);
		chk("int_b", {mdl[8'h22][7:4], mdl[8'h21]}, int_b);
		put(8'h10, 8'h00);
		for (int k = 0; k < 8; k++) begin
			put(8'h24, 8'(k));
			repeat (3) @(negedge mclk);
			chk("mult_sel", k % 4, mult_sel);
			chk("mult_q", qtab[k % 4], mult_q);
			chk("mult_en", k / 4, mult_en);
		end
		$display("test register map done");
		// x1 with the stage bit clear, so only spread can enable it
		put(8'h24, 8'h01);
		base = {8'(4 + $urandom % 252), 16'($urandom)};
		// base is the triangle top, the highest divider value
		put(8'h12, base[23:16]);
		put(8'h13, base[15:8]);
		put(8'h14, base[7:0]);
		per = 2;
		stp = 16'($urandom);
		put(8'h11, 8'(per));
		put(8'h15, 8'(stp >> 8));
		put(8'h16, 8'(stp));
		repeat (3) tick();
		chk("mult_en", 0, mult_en);
		$display("test spread off done");
		put(8'h10, 8'h80);
		en = 1;
		repeat (3) @(negedge mclk);
		chk("mod_active", 1, mod_active);
		chk("mult_en", 1, mult_en);
		chk("mult_q", 4'h4, mult_q);
		repeat (22) tick();
		chk("int_a", {mdl[8'h22][3:0], mdl[8'h20]}, int_a);
		put(8'h10, 8'h00);
		{off, cnt, up, en} = '0;
		tick();
		chk("mod_active", 0, mod_active);
		chk("mult_en", 0, mult_en);
		$display("test spread ramp done");
		wrap_up();
	end
endmodule
